// *** include/edft_pkg.sv ***
/*
 Shared constants for the E3 data-link frame transmitter: register offsets,
 bit positions, reset values, framing octets and the transmitter states.
 Assumes an 8-bit microprocessor port with byte-wide registers.
*/
package edft_pkg;
	// register offsets on the microprocessor port
	localparam logic [7:0] ADDR_OP_MODE  = 8'h00; // framer operating mode
	localparam logic [7:0] ADDR_TX_CFG   = 8'h30; // transmit E3 configuration
	localparam logic [7:0] ADDR_DL_CFG   = 8'h33; // data-link transmit configuration
	localparam logic [7:0] ADDR_DL_STAT  = 8'h34; // data-link status and interrupt
	localparam logic [7:0] ADDR_BUF_LO   = 8'h8A; // first message buffer octet
	localparam logic [7:0] ADDR_BUF_HI   = 8'hDB; // last message buffer octet
	// bit positions
	localparam int BIT_AUTO_CLR  = 3; // operating mode: automatic interrupt clear
	localparam int BIT_LINK_DIS  = 3; // transmit config: data link disable
	localparam int BIT_DL_EN     = 0; // data-link config: transmitter enable
	localparam int BIT_SIZE_SEL  = 1; // data-link config: message size select
	localparam int BIT_RESEND    = 3; // data-link config: periodic resend
	localparam int BIT_START     = 3; // status: message start
	localparam int BIT_BUSY      = 2; // status: busy
	localparam int BIT_IRQ_EN    = 1; // status: done interrupt enable
	localparam int BIT_IRQ_FLAG  = 0; // status: done interrupt flag
	// reset values
	localparam logic [7:0] RST_OP_MODE = 8'h2B;
	localparam logic [7:0] RST_ZERO    = 8'h00;
	// framing
	localparam logic [7:0]  FLAG_OCTET = 8'h7E;   // opening, closing and fill flag
	localparam logic [15:0] CRC_POLY_R = 16'h8408; // x^16+x^12+x^5+1, bit reversed
	localparam logic [15:0] CRC_INIT   = 16'hFFFF;
	localparam logic [6:0]  BODY_SHORT = 7'h4C;    // 76 octets
	localparam logic [6:0]  BODY_LONG  = 7'h52;    // 82 octets
	localparam logic [2:0]  STUFF_RUN  = 3'h5;     // ones before a stuffed zero
	localparam logic [2:0]  LAST_BIT   = 3'h7;
	// transmitter states
	typedef enum logic [2:0] {
		ST_FILL, ST_OPEN, ST_BODY, ST_FCS_LO, ST_FCS_HI, ST_CLOSE
	} edft_state_t;
endpackage

// *** verilog/edft_crc16.sv ***
/*
 Bit-serial frame check value generator, least significant bit first.
 Assumes the caller clears it before the opening flag and enables it
 once per bit that the check value covers.
*/
`timescale 1ns/1ps
module edft_crc16 (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        clear,  // restart at the initial value
	input  wire logic        enable, // fold one bit in
	input  wire logic        bitIn,  // bit being sent
	output logic [15:0]      crc     // running remainder
);
	// shift register with reversed polynomial feedback
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			crc <= edft_pkg::CRC_INIT;
		end else if (clear) begin
			crc <= edft_pkg::CRC_INIT;
		end else if (enable) begin
			crc <= (crc >> 1) ^ ((crc[0] ^ bitIn) ? edft_pkg::CRC_POLY_R : 16'h0000);
		end
	end
endmodule // edft_crc16

// *** verilog/edft_stuffer.sv ***
/*
 Zero insertion tracker. Counts ones leaving on the line and asks for a
 zero after a run of five. Assumes one advance per N-bit opportunity.
*/
`timescale 1ns/1ps
module edft_stuffer (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic slot,      // one line bit leaves this cycle
	input  wire logic stuffOn,   // bit belongs to the stuffed region
	input  wire logic dataBit,   // bit offered by the serializer
	output logic      insertNow  // next line bit must be a stuffed zero
);
	logic [2:0] onesRun_q; // ones sent back to back in the stuffed region

	// a run that ends on the last check bit still forces the zero before the
	// closing flag, so the request does not look at stuffOn
	assign insertNow = (onesRun_q == edft_pkg::STUFF_RUN);

	// run counter, advanced only when a line bit leaves
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			onesRun_q <= 3'h0;
		end else if (slot) begin
			if (insertNow) begin
				onesRun_q <= 3'h0;
			end else if (stuffOn && dataBit) begin
				onesRun_q <= onesRun_q + 3'h1;
			end else begin
				onesRun_q <= 3'h0;
			end
		end
	end
endmodule // edft_stuffer

// *** verilog/edft_transmitter.sv ***
/*
 E3 data-link message transmitter: register port, message buffer, frame
 sequencer and serializer feeding the N overhead bit of each E3 frame.
 Assumes the framer gives one nBitSlot pulse per outbound frame and a
 oneSecTick pulse from its one-second reference, both on clk.
*/
`timescale 1ns/1ps
module edft_transmitter #(
	parameter int BUF_DEPTH = 82 // message buffer octets
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] cpuAddr,    // register or buffer address
	input  wire logic [7:0] cpuWrData,  // write data
	input  wire logic       cpuWrEn,    // write strobe, one cycle
	input  wire logic       cpuRdEn,    // read strobe, one cycle
	output logic [7:0]      cpuRdData,  // read data, cycle after cpuRdEn
	input  wire logic       nBitSlot,   // N-bit opportunity of one E3 frame
	input  wire logic       oneSecTick, // one-second reference pulse
	output logic            nBit,       // N overhead bit value
	output logic            txDoneIrq   // done interrupt, active high
);
	localparam int IW = $clog2(BUF_DEPTH);

	// true when an address falls inside the message buffer
	function automatic logic inBuf(input logic [7:0] a);
		return (a >= edft_pkg::ADDR_BUF_LO) && (a <= edft_pkg::ADDR_BUF_HI);
	endfunction

	// buffer index of an address inside the buffer window
	function automatic logic [IW-1:0] bufIdx(input logic [7:0] a);
		logic [7:0] d;
		d = a - edft_pkg::ADDR_BUF_LO;
		return d[IW-1:0];
	endfunction

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic [7:0]           opMode_q;          // operating mode register
	logic [7:0]           txCfg_q;           // transmit E3 configuration
	logic [7:0]           dlCfg_q;           // data-link configuration
	logic                 startBit_q;        // start bit as last written
	logic                 irqEn_q;           // done interrupt enable
	logic                 doneFlag_q;        // done interrupt flag
	logic                 busy_q;            // frame in progress
	logic                 startPend_q;       // accepted start awaiting boundary
	logic                 resendPend_q;      // second tick awaiting boundary
	logic                 resendFrame_q;     // frame in flight is a resend
	logic                 sentOnce_q;        // a frame has gone out since enable
	logic [7:0]           msgBuf_q [BUF_DEPTH]; // message buffer
	edft_pkg::edft_state_t state_q;          // sequencer state
	logic [2:0]           bitIdx_q;          // bit within current octet
	logic [IW-1:0]        byteIdx_q;         // octet within body
	logic [7:0]           curByte;           // octet being serialized
	logic                 dataBit;           // bit offered to the line
	logic                 insertNow;         // stuffed zero due
	logic                 stuffOn;           // bit lies between the flags
	logic [15:0]          crc;               // running check value
	logic                 txOn;              // transmitter enabled
	logic                 startRise;         // start bit written 0 to 1
	logic                 statRead;          // status register read
	logic                 byteEnd;           // last bit of an octet leaves
	logic                 frameGo;           // frame begins at this boundary
	logic                 frameDone;         // closing flag fully sent
	logic                 doneSet;           // done flag to be raised
	logic [IW-1:0]        bodyLast;          // index of last body octet

	// enable needs the data-link enable and no link disable
	assign txOn      = dlCfg_q[edft_pkg::BIT_DL_EN] && !txCfg_q[edft_pkg::BIT_LINK_DIS];
	assign startRise = cpuWrEn && (cpuAddr == edft_pkg::ADDR_DL_STAT)
	                   && cpuWrData[edft_pkg::BIT_START] && !startBit_q;
	assign statRead  = cpuRdEn && (cpuAddr == edft_pkg::ADDR_DL_STAT);
	assign bodyLast  = dlCfg_q[edft_pkg::BIT_SIZE_SEL] ? IW'(edft_pkg::BODY_LONG - 7'h1)
	                                                   : IW'(edft_pkg::BODY_SHORT - 7'h1);
	assign stuffOn   = (state_q == edft_pkg::ST_BODY) || (state_q == edft_pkg::ST_FCS_LO)
	                   || (state_q == edft_pkg::ST_FCS_HI);
	assign byteEnd   = nBitSlot && txOn && !insertNow && (bitIdx_q == edft_pkg::LAST_BIT);
	assign frameGo   = byteEnd && (state_q == edft_pkg::ST_FILL) && (startPend_q || resendPend_q);
	assign frameDone = byteEnd && (state_q == edft_pkg::ST_CLOSE);
	// resend frames stay silent while automatic clear is on
	assign doneSet   = frameDone && !(resendFrame_q && opMode_q[edft_pkg::BIT_AUTO_CLR]);

	// configuration registers written from the microprocessor port
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			opMode_q   <= edft_pkg::RST_OP_MODE;
			txCfg_q    <= edft_pkg::RST_ZERO;
			dlCfg_q    <= edft_pkg::RST_ZERO;
			startBit_q <= 1'b0;
			irqEn_q    <= 1'b0;
		end else if (cpuWrEn) begin
			unique case (cpuAddr)
				edft_pkg::ADDR_OP_MODE: opMode_q <= cpuWrData;
				edft_pkg::ADDR_TX_CFG:  txCfg_q  <= cpuWrData;
				edft_pkg::ADDR_DL_CFG: begin
					// only enable, size and resend bits are stored
					dlCfg_q[edft_pkg::BIT_DL_EN]    <= cpuWrData[edft_pkg::BIT_DL_EN];
					dlCfg_q[edft_pkg::BIT_SIZE_SEL] <= cpuWrData[edft_pkg::BIT_SIZE_SEL];
					dlCfg_q[edft_pkg::BIT_RESEND]   <= cpuWrData[edft_pkg::BIT_RESEND];
				end
				edft_pkg::ADDR_DL_STAT: begin
					startBit_q <= cpuWrData[edft_pkg::BIT_START];
					irqEn_q    <= cpuWrData[edft_pkg::BIT_IRQ_EN];
				end
				default: ; // buffer and unmapped writes handled elsewhere or dropped
			endcase
		end
	end

	// message buffer; writes during a resend can tear the frame on the wire
	always_ff @(posedge clk) begin
		if (cpuWrEn && inBuf(cpuAddr)) begin
			msgBuf_q[bufIdx(cpuAddr)] <= cpuWrData;
		end
	end

	// start, resend and busy bookkeeping
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			startPend_q   <= 1'b0;
			resendPend_q  <= 1'b0;
			resendFrame_q <= 1'b0;
			busy_q        <= 1'b0;
			sentOnce_q    <= 1'b0;
		end else if (!txOn) begin
			startPend_q   <= 1'b0;
			resendPend_q  <= 1'b0;
			resendFrame_q <= 1'b0;
			busy_q        <= 1'b0;
			sentOnce_q    <= 1'b0;
		end else begin
			if (startRise && !busy_q) begin
				startPend_q <= 1'b1;
				busy_q      <= 1'b1;
			end
			if (oneSecTick && dlCfg_q[edft_pkg::BIT_RESEND] && sentOnce_q && !busy_q) begin
				resendPend_q <= 1'b1;
			end
			if (frameGo) begin
				startPend_q   <= 1'b0;
				resendPend_q  <= 1'b0;
				resendFrame_q <= !startPend_q;
				busy_q        <= 1'b1;
			end
			if (frameDone) begin
				busy_q     <= 1'b0;
				sentOnce_q <= 1'b1;
			end
		end
	end

	a_start_accept: assert property ((startRise && !busy_q && txOn) |=> busy_q && startPend_q)
		else $error("accepted start did not raise busy");
	a_start_busy: assert property ((startRise && busy_q && txOn && !frameDone)
		|=> busy_q && $stable(state_q) || $past(nBitSlot))
		else $error("start while busy disturbed the frame");
	a_resend_arm: assert property ((oneSecTick && txOn && dlCfg_q[edft_pkg::BIT_RESEND] && sentOnce_q
		&& !busy_q && !frameGo) |=> resendPend_q)
		else $error("second tick did not arm a resend");

	// octet selection for the serializer
	always_comb begin
		unique case (state_q)
			edft_pkg::ST_BODY:   curByte = msgBuf_q[byteIdx_q];
			edft_pkg::ST_FCS_LO: curByte = ~crc[7:0];
			edft_pkg::ST_FCS_HI: curByte = ~crc[15:8];
			default:             curByte = edft_pkg::FLAG_OCTET;
		endcase
	end
	assign dataBit = curByte[bitIdx_q];

	// sequencer and line bit, stepped once per N-bit opportunity
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q   <= edft_pkg::ST_FILL;
			bitIdx_q  <= 3'h0;
			byteIdx_q <= '0;
			nBit      <= 1'b1;
		end else if (!txOn) begin
			state_q   <= edft_pkg::ST_FILL;
			bitIdx_q  <= 3'h0;
			byteIdx_q <= '0;
			nBit      <= 1'b1;
		end else if (nBitSlot) begin
			if (insertNow) begin
				nBit <= 1'b0;
			end else begin
				nBit     <= dataBit;
				bitIdx_q <= bitIdx_q + 3'h1;
				if (bitIdx_q == edft_pkg::LAST_BIT) begin
					unique case (state_q)
						edft_pkg::ST_FILL: begin
							if (frameGo) begin
								state_q <= edft_pkg::ST_OPEN;
							end
						end
						edft_pkg::ST_OPEN: begin
							state_q   <= edft_pkg::ST_BODY;
							byteIdx_q <= '0;
						end
						edft_pkg::ST_BODY: begin
							if (byteIdx_q == bodyLast) begin
								state_q <= edft_pkg::ST_FCS_LO;
							end else begin
								byteIdx_q <= byteIdx_q + IW'(1);
							end
						end
						edft_pkg::ST_FCS_LO: state_q <= edft_pkg::ST_FCS_HI;
						edft_pkg::ST_FCS_HI: state_q <= edft_pkg::ST_CLOSE;
						edft_pkg::ST_CLOSE:  state_q <= edft_pkg::ST_FILL;
						default:             state_q <= edft_pkg::ST_FILL;
					endcase
				end
			end
		end
	end

	a_disabled_ones: assert property ((!txOn) |=> nBit && state_q == edft_pkg::ST_FILL)
		else $error("disabled link did not send ones");
	a_stuff_zero: assert property ((nBitSlot && txOn && insertNow) |=> !nBit && $stable(bitIdx_q))
		else $error("stuffed zero missing");
	a_body_length: assert property ((byteEnd && state_q == edft_pkg::ST_BODY && byteIdx_q == bodyLast)
		|=> state_q == edft_pkg::ST_FCS_LO)
		else $error("body length wrong before check value");
	a_close_follows: assert property ((byteEnd && state_q == edft_pkg::ST_FCS_HI)
		|=> state_q == edft_pkg::ST_CLOSE && bitIdx_q == 3'h0)
		else $error("closing flag did not follow check value");
	a_flags_plain: assert property ((nBitSlot && txOn && (state_q == edft_pkg::ST_OPEN || state_q == edft_pkg::ST_FILL))
		|-> !insertNow && !stuffOn)
		else $error("flag octet marked for stuffing");
	a_busy_span: assert property (frameDone |=> !busy_q)
		else $error("busy stayed high after frame");

	c_frame_done:  cover property (frameDone);
	c_stuffed:     cover property (nBitSlot && insertNow && stuffOn);
	c_resend_sent: cover property (frameDone && resendFrame_q);

	// check value over opening flag and body, frozen during its own octets
	edft_crc16 u_crc (
		.clk    (clk),
		.rst_n  (rst_n),
		.clear  (frameGo),
		.enable (nBitSlot && txOn && !insertNow
		         && (state_q == edft_pkg::ST_OPEN || state_q == edft_pkg::ST_BODY)),
		.bitIn  (dataBit),
		.crc    (crc)
	);

	// zero insertion applied as bits leave, no stuffed copy is kept
	edft_stuffer u_stuff (
		.clk       (clk),
		.rst_n     (rst_n),
		.slot      (nBitSlot || !txOn), // disabled cycles flush the run, so a re-enabled link opens unstuffed
		.stuffOn   (stuffOn),
		.dataBit   (dataBit),
		.insertNow (insertNow)
	);

	// done flag: hardware set wins over the read clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			doneFlag_q <= 1'b0;
		end else if (doneSet) begin
			doneFlag_q <= 1'b1;
		end else if (statRead) begin
			doneFlag_q <= 1'b0;
		end
	end

	// interrupt line gated by the enable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			txDoneIrq <= 1'b0;
		end else begin
			txDoneIrq <= doneFlag_q && irqEn_q;
		end
	end

	a_read_clear: assert property ((statRead && !doneSet) |=> !doneFlag_q ##1 !txDoneIrq)
		else $error("status read did not clear done flag");
	a_irq_follow: assert property ((doneSet && irqEn_q) |=> ##1 txDoneIrq)
		else $error("enabled done did not interrupt");
	a_auto_quiet: assert property ((frameDone && resendFrame_q && opMode_q[edft_pkg::BIT_AUTO_CLR]
		&& !doneFlag_q) |=> !doneFlag_q)
		else $error("resend raised interrupt under auto clear");

	// registered read port; unmapped addresses read zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cpuRdData <= 8'h00;
		end else if (cpuRdEn) begin
			if (inBuf(cpuAddr)) begin
				cpuRdData <= msgBuf_q[bufIdx(cpuAddr)];
			end else begin
				unique case (cpuAddr)
					edft_pkg::ADDR_OP_MODE: cpuRdData <= opMode_q;
					edft_pkg::ADDR_TX_CFG:  cpuRdData <= txCfg_q;
					edft_pkg::ADDR_DL_CFG:  cpuRdData <= dlCfg_q;
					edft_pkg::ADDR_DL_STAT: cpuRdData <= {4'h0, startBit_q, busy_q, irqEn_q, doneFlag_q};
					default:                cpuRdData <= 8'h00;
				endcase
			end
		end
	end
endmodule // edft_transmitter

// *** dv/edft_far_framer.sv ***
/*
 Far-end framer model: hands out one N-bit opportunity per E3 frame and
 takes the line bit that the transmitter places there.
 Assumes nBit settles on the cycle after each opportunity.
*/
`timescale 1ns/1ps
module edft_far_framer (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic slow,     // widen the spacing of opportunities
	input  wire logic nBit,     // line bit from the transmitter
	output logic      nBitSlot, // opportunity pulse
	output logic      rxValid,  // a line bit was taken
	output logic      rxBit     // the bit taken
);
	logic [3:0] gapCnt_q; // cycles until the next opportunity
	logic       lag_q;    // opportunity seen last cycle

	// opportunities every 3 or 11 cycles; real framers are slower still
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gapCnt_q <= 4'h0;
			nBitSlot <= 1'b0;
		end else begin
			nBitSlot <= (gapCnt_q == 4'h0);
			gapCnt_q <= (gapCnt_q == 4'h0) ? (slow ? 4'hA : 4'h2) : gapCnt_q - 4'h1;
		end
	end

	// take the bit one cycle after the opportunity, once it has settled
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lag_q   <= 1'b0;
			rxValid <= 1'b0;
			rxBit   <= 1'b1;
		end else begin
			lag_q   <= nBitSlot;
			rxValid <= lag_q;
			rxBit   <= nBit;
		end
	end
endmodule // edft_far_framer

// *** dv/edft_tb.sv ***
/*
 Self-checking bench for the data-link frame transmitter: register port,
 framing, stuffing, check value, status and resend.
 Assumes the far-end framer model and a 100 MHz clock.
*/
`timescale 1ns/1ps
module tb;
	logic       clk, rst_n, cpuWrEn, cpuRdEn, oneSecTick, slow;
	logic [7:0] cpuAddr, cpuWrData, cpuRdData, rv;
	logic       nBitSlot, nBit, txDoneIrq, rxValid, rxBit;
	int         mismatches, checks, seed, ones;
	logic       rxQ[$];  // line bits taken by the far end
	logic [7:0] mem[82]; // model of the message buffer
	logic [7:0] fr[$];   // octets of the last frame seen
	logic [7:0] ra[5] = '{8'h00, 8'h30, 8'h33, 8'h34, 8'h50}; // reset table
	logic [7:0] re[5] = '{8'h2B, 8'h00, 8'h00, 8'h00, 8'h00};

	edft_transmitter #(.BUF_DEPTH(82)) u_dut (.clk(clk), .rst_n(rst_n), .cpuAddr(cpuAddr),
		.cpuWrData(cpuWrData), .cpuWrEn(cpuWrEn), .cpuRdEn(cpuRdEn), .cpuRdData(cpuRdData),
		.nBitSlot(nBitSlot), .oneSecTick(oneSecTick), .nBit(nBit), .txDoneIrq(txDoneIrq));
	edft_far_framer u_far (.clk(clk), .rst_n(rst_n), .slow(slow), .nBit(nBit),
		.nBitSlot(nBitSlot), .rxValid(rxValid), .rxBit(rxBit));

	// clock at 100 MHz
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// keep every line bit so register traffic never loses any
	always @(posedge clk) if (rxValid) rxQ.push_back(rxBit);

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		cpuAddr = a;
		cpuWrData = d;
		cpuWrEn = 1'b1;
		@(negedge clk);
		cpuWrEn = 1'b0;
	endtask
	// data stands from the cycle after the strobe until the next read
	task automatic rd(input logic [7:0] a);
		@(negedge clk);
		cpuAddr = a;
		cpuRdEn = 1'b1;
		@(negedge clk);
		cpuRdEn = 1'b0;
		@(negedge clk);
		rv = cpuRdData;
	endtask
	task automatic tick();
		@(negedge clk);
		oneSecTick = 1'b1;
		@(negedge clk);
		oneSecTick = 1'b0;
	endtask
	// random body with runs of ones so that stuffing is exercised
	task automatic load();
		for (int i = 0; i < 82; i++) begin
			mem[i] = (i % 7 == 3) ? 8'hFF : 8'($random(seed));
			wr(8'(8'h8A + i), mem[i]);
		end
	endtask
	function automatic logic [15:0] frame_check_value(input int n);
		logic [15:0] c;
		logic [7:0]  b;
		c = 16'hFFFF;
		for (int i = -1; i < n; i++) begin
			b = (i < 0) ? 8'h7E : mem[i];
			for (int k = 0; k < 8; k++) c = (c[0] ^ b[k]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
		end
		return ~c;
	endfunction
	// receiver: hunt flags, drop the zero after five ones, pack LSB first
	task automatic get_frame(input int maxBits);
		logic [7:0] sh, cur;
		logic       b;
		logic       db[$];
		int         w, n;
		sh = 8'h00;
		fr.delete();
		for (int i = 0; i < maxBits; i++) begin
			w = 0;
			while (rxQ.size() == 0 && w < 60) begin
				@(negedge clk);
				w++;
			end
			if (rxQ.size() == 0) begin
				mismatches++;
				$display("wrong value at %0t: line bits stopped", $time);
				close_out();
			end
			b = rxQ.pop_front();
			sh = {b, sh[7:1]};
			if (sh == 8'h7E) begin
				n = db.size() - 7;
				if (n >= 16 && n % 8 == 0) begin
					for (int j = 0; j < n; j++) begin
						cur[j % 8] = db[j];
						if (j % 8 == 7) fr.push_back(cur);
					end
					ones = 0;
					return;
				end
				db.delete();
			end else if (!(ones == 5 && !b)) begin
				db.push_back(b);
			end
			ones = b ? ones + 1 : 0;
			// seven ones is idle or abort, so nothing collected so far is a frame
			if (ones >= 7) db.delete();
		end
	endtask
	task automatic check_frame(input int n);
		chk(16'(fr.size()), 16'(n + 2));
		if (fr.size() == n + 2) begin
			for (int i = 0; i < n; i++) chk(fr[i], mem[i]);
			chk({fr[n + 1], fr[n]}, frame_check_value(n));
		end
	endtask

	initial begin
		seed = 5223;
		mismatches = 0;
		checks = 0;
		ones = 0;
		rst_n = 1'b0;
		cpuAddr = 8'h00;
		cpuWrData = 8'h00;
		cpuWrEn = 1'b0;
		cpuRdEn = 1'b0;
		oneSecTick = 1'b0;
		slow = 1'b0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		// reset values, unmapped place, read-only bits
		foreach (ra[i]) begin
			rd(ra[i]);
			chk(rv, re[i]);
		end
		wr(8'h33, 8'hF4);
		wr(8'h34, 8'hF5);
		wr(8'h50, 8'hFF);
		foreach (ra[i]) if (i > 1) begin
			rd(ra[i]);
			chk(rv, 8'h00);
		end
		chk(nBit, 1'b1);
		$display("test registers done");
		// single frame, short body, interrupt on, restart while busy
		load();
		wr(8'h33, 8'h01);
		wr(8'h34, 8'h02);
		wr(8'h34, 8'h0A);
		rd(8'h34);
		chk(rv, 8'h0E);
		wr(8'h34, 8'h02);
		wr(8'h34, 8'h0A);
		get_frame(3000);
		check_frame(76);
		repeat (3) @(negedge clk);
		chk(txDoneIrq, 1'b1);
		rd(8'h34);
		chk(rv, 8'h0B);
		repeat (2) @(negedge clk);
		chk(txDoneIrq, 1'b0);
		get_frame(400);
		chk(16'(fr.size()), 16'h0000);
		$display("test single done");
		// long body, slow opportunities, interrupt off
		slow = 1'b1;
		load();
		wr(8'h33, 8'h03);
		wr(8'h34, 8'h00);
		wr(8'h34, 8'h08);
		get_frame(6000);
		check_frame(82);
		repeat (3) @(negedge clk);
		chk(txDoneIrq, 1'b0);
		rd(8'h34);
		chk(rv, 8'h09);
		$display("test long done");
		// periodic resend, automatic clear on then off
		slow = 1'b0;
		wr(8'h34, 8'h02);
		wr(8'h33, 8'h0B);
		tick();
		get_frame(3000);
		check_frame(82);
		repeat (3) @(negedge clk);
		chk(txDoneIrq, 1'b0);
		rd(8'h34);
		chk(rv, 8'h02);
		get_frame(400);
		chk(16'(fr.size()), 16'h0000);
		wr(8'h00, 8'h23);
		tick();
		get_frame(3000);
		check_frame(82);
		repeat (3) @(negedge clk);
		chk(txDoneIrq, 1'b1);
		$display("test resend done");
		// link disable forces ones and idles the sequencer
		wr(8'h30, 8'h08);
		repeat (30) begin
			@(negedge clk);
			chk(nBit, 1'b1);
		end
		rd(8'h34);
		chk(rv[2], 1'b0);
		$display("test disable done");
		close_out();
	end
endmodule // tb
